/* hdl/brownout_regulator_pkg.sv */
// Purpose: Shared constants and types for the brown-out and regulator block
// Assumes: AXI4-Lite register bus, 32-bit data, 40 MHz aclk
// Notes: Register offsets are byte addresses
package brownout_regulator_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_REGULATOR_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RESET_CAUSE = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_SEQ_STATUS = 8'h10;
    localparam int LP_BIT = 15;
    localparam int PLL_V_LSB = 4;
    localparam int CORE_V_LSB = 0;
    localparam int BROWNOUT_FLAG_BIT = 1;
    localparam int LOCK_BIT = 5;
    localparam logic [15:0] REG_CTRL_MASK = 16'h8033;
    localparam logic [15:0] REG_CTRL_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Regulator output level decoded from a two-bit voltage code
    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_MID = 2'h1,
        LVL_HIGH = 2'h2
    } level_t;
    // Sequencer status reported to the rest of the device
    typedef struct packed {
        logic device_reset;
        logic clock_gate;
        logic por_wait;
    } seq_status_t;
    // Regulator drive outputs
    typedef struct packed {
        logic low_power;
        logic standby;
        level_t core_level;
        level_t pll_level;
    } reg_drive_t;
    // Irq bits: bit 0 brown-out event, bit 1 reset released
    localparam int IRQ_W = 2;
    localparam int IRQ_BROWNOUT = 0;
    localparam int IRQ_REL = 1;
    localparam int RST_PULSE_NS = 100;
    localparam int CLK_NS = 25;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] CODE_LOW = 2'h1;
    localparam logic [1:0] CODE_MID = 2'h2;
endpackage

/* hdl/brownout_regulator_control.sv */
// Purpose: Regulator control register and brown-out reset sequencer
// Assumes: Brown-out and lock inputs are asynchronous and pass two flops
// Notes: Timer lengths are parameters in aclk cycles
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Low-power enable bit puts both regulators in low-power mode when one
// - PLL voltage code 11/00 high, 10 middle, 01 lowest level
// - Core voltage code uses same encoding, written independently of PLL code
// - Unused regulator control bits always read back as zero
// - Regulators go to low-power standby while the device sleeps
// - A detected brown-out produces a reset pulse for the whole device
// - Clock source for restart is taken from configuration inputs
// - Oscillator mode without PLL starts start-up timer; clock gated until it expires
// - PLL mode keeps clock gated until the PLL lock flag is one
// - Power-up timer delay runs alongside clock wait before reset release
// - Zero power-up delay with crystal uses clock monitor delay instead
// - A brown-out reset sets bit one of the reset cause register
// - Brown-out detection keeps working in sleep and idle modes
module brownout_regulator_control #(
    parameter int STARTUP_CYCLES = 1024,
    parameter int POWERUP_CYCLES = 2560,
    parameter int FSCM_CYCLES = 200
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [brownout_regulator_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [brownout_regulator_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic brownout_detect,
    input wire logic [7:0] oscillator_control_register,
    input wire logic cfg_osc_mode,
    input wire logic cfg_pll_used,
    input wire logic cfg_crystal,
    input wire logic cfg_power_up_timer_zero,
    input wire logic sleep_mode,
    output var brownout_regulator_pkg::reg_drive_t reg_drive,
    output var brownout_regulator_pkg::seq_status_t seq_status,
    output logic irq
);
    if (STARTUP_CYCLES < 1 || POWERUP_CYCLES < 1 ||
        FSCM_CYCLES < 1) begin : g_bad_timer
        $error("Timer lengths must be at least one cycle");
    end

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic detect_s1_q, detect_s2_q, lock_s1_q, lock_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detect_s1_q <= 1'b0;
            detect_s2_q <= 1'b0;
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            detect_s1_q <= brownout_detect;
            detect_s2_q <= detect_s1_q;
            lock_s1_q <=
                oscillator_control_register[brownout_regulator_pkg::LOCK_BIT];
            lock_s2_q <= lock_s1_q;
        end
    end

    // ************************************************************
    // Brown-out sequencer
    // ************************************************************
    typedef enum {ST_RUN, ST_PULSE, ST_WAIT} seq_t;
    localparam logic [31:0] PULSE_LOAD =
        32'(brownout_regulator_pkg::RST_PULSE_CYC - 1);
    seq_t state_q;
    logic [31:0] pulse_cnt_q, clk_cnt_q, pwr_cnt_q;
    logic clk_done, pwr_done, brownout_ev;
    logic use_fscm;
    assign use_fscm = cfg_power_up_timer_zero && cfg_crystal;
    assign brownout_ev = detect_s2_q && state_q == ST_RUN;
    assign clk_done = cfg_pll_used ? lock_s2_q :
        (cfg_osc_mode ? clk_cnt_q == 32'h0 : 1'b1);
    assign pwr_done = pwr_cnt_q == 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RUN;
            pulse_cnt_q <= 32'h0;
            clk_cnt_q <= 32'h0;
            pwr_cnt_q <= 32'h0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (detect_s2_q) begin
                        state_q <= ST_PULSE;
                        pulse_cnt_q <= PULSE_LOAD;
                    end
                end
                ST_PULSE: begin
                    if (detect_s2_q) begin
                        pulse_cnt_q <= PULSE_LOAD;
                    end else if (pulse_cnt_q != 32'h0) begin
                        pulse_cnt_q <= pulse_cnt_q - 32'h1;
                    end else begin
                        state_q <= ST_WAIT;
                        clk_cnt_q <= 32'(STARTUP_CYCLES - 1);
                        pwr_cnt_q <= use_fscm ? 32'(FSCM_CYCLES - 1) :
                            32'(POWERUP_CYCLES - 1);
                    end
                end
                ST_WAIT: begin
                    if (detect_s2_q) begin
                        state_q <= ST_PULSE;
                        pulse_cnt_q <= PULSE_LOAD;
                    end else begin
                        if (clk_cnt_q != 32'h0) begin
                            clk_cnt_q <= clk_cnt_q - 32'h1;
                        end
                        if (pwr_cnt_q != 32'h0) begin
                            pwr_cnt_q <= pwr_cnt_q - 32'h1;
                        end
                        if (clk_done && pwr_done) begin
                            state_q <= ST_RUN;
                        end
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    logic release_ev;
    assign release_ev = state_q == ST_WAIT && !detect_s2_q && clk_done &&
        pwr_done;

    always_comb begin
        seq_status.device_reset = state_q != ST_RUN;
        seq_status.clock_gate = state_q == ST_PULSE ||
            (state_q == ST_WAIT && !clk_done);
        seq_status.por_wait = state_q == ST_WAIT && !pwr_done;
    end

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [15:0] reg_ctrl_q;
    logic brownout_flag_q;
    logic [1:0] irq_status_q, irq_mask_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= brownout_regulator_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    brownout_regulator_pkg::OFF_REGULATOR_CONTROL,
                    brownout_regulator_pkg::OFF_RESET_CAUSE,
                    brownout_regulator_pkg::OFF_IRQ_STATUS,
                    brownout_regulator_pkg::OFF_IRQ_MASK,
                    brownout_regulator_pkg::OFF_SEQ_STATUS:
                        s_axi_bresp <= brownout_regulator_pkg::RESP_OKAY;
                    default: s_axi_bresp <= brownout_regulator_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_ctrl, wr_cause, wr_stat, wr_mask;
    assign wr_ctrl = do_write &&
        aw_addr_q == brownout_regulator_pkg::OFF_REGULATOR_CONTROL;
    assign wr_cause = do_write && w_strb_q[0] &&
        aw_addr_q == brownout_regulator_pkg::OFF_RESET_CAUSE;
    assign wr_stat = do_write && w_strb_q[0] &&
        aw_addr_q == brownout_regulator_pkg::OFF_IRQ_STATUS;
    assign wr_mask = do_write && w_strb_q[0] &&
        aw_addr_q == brownout_regulator_pkg::OFF_IRQ_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ctrl_q <= brownout_regulator_pkg::REG_CTRL_RESET;
        end else if (wr_ctrl) begin
            if (w_strb_q[0]) begin
                reg_ctrl_q[7:0] <= w_data_q[7:0] &
                    brownout_regulator_pkg::REG_CTRL_MASK[7:0];
            end
            if (w_strb_q[1]) begin
                reg_ctrl_q[15:8] <= w_data_q[15:8] &
                    brownout_regulator_pkg::REG_CTRL_MASK[15:8];
            end
        end
    end

    // Set wins over the software clear; flag survives the reset it causes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brownout_flag_q <= 1'b0;
        end else if (brownout_ev) begin
            brownout_flag_q <= 1'b1;
        end else if (wr_cause &&
            !w_data_q[brownout_regulator_pkg::BROWNOUT_FLAG_BIT]) begin
            brownout_flag_q <= 1'b0;
        end
    end

    logic [1:0] irq_set;
    assign irq_set = {release_ev, brownout_ev};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            irq_status_q <= (irq_status_q &
                ~(wr_stat ? w_data_q[1:0] : 2'h0)) | irq_set;
            if (wr_mask) begin
                irq_mask_q <= w_data_q[1:0];
            end
        end
    end
    assign irq = |(irq_status_q & irq_mask_q);

    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            brownout_regulator_pkg::OFF_REGULATOR_CONTROL:
                rd_word[15:0] = reg_ctrl_q;
            brownout_regulator_pkg::OFF_RESET_CAUSE:
                rd_word[brownout_regulator_pkg::BROWNOUT_FLAG_BIT] =
                    brownout_flag_q;
            brownout_regulator_pkg::OFF_IRQ_STATUS: rd_word[1:0] = irq_status_q;
            brownout_regulator_pkg::OFF_IRQ_MASK: rd_word[1:0] = irq_mask_q;
            brownout_regulator_pkg::OFF_SEQ_STATUS:
                rd_word[2:0] = seq_status;
            default: rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= brownout_regulator_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? brownout_regulator_pkg::RESP_OKAY :
                brownout_regulator_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Regulator drive
    // ************************************************************
    function automatic brownout_regulator_pkg::level_t decode(logic [1:0] c);
        if (c == brownout_regulator_pkg::CODE_LOW) begin
            return brownout_regulator_pkg::LVL_LOW;
        end else if (c == brownout_regulator_pkg::CODE_MID) begin
            return brownout_regulator_pkg::LVL_MID;
        end
        return brownout_regulator_pkg::LVL_HIGH;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_drive <= '{1'b0, 1'b0, brownout_regulator_pkg::LVL_HIGH,
                brownout_regulator_pkg::LVL_HIGH};
        end else begin
            reg_drive.low_power <= reg_ctrl_q[brownout_regulator_pkg::LP_BIT];
            reg_drive.standby <= sleep_mode;
            reg_drive.core_level <=
                decode(reg_ctrl_q[brownout_regulator_pkg::CORE_V_LSB +: 2]);
            reg_drive.pll_level <=
                decode(reg_ctrl_q[brownout_regulator_pkg::PLL_V_LSB +: 2]);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence brownout_seen_s;
        detect_s2_q && state_q == ST_RUN;
    endsequence

    brownout_pulse_a: assert property (
        brownout_seen_s |=> seq_status.device_reset [*4])
        else $error("Brown-out did not hold device reset");
    flag_set_a: assert property (
        brownout_seen_s |=> brownout_flag_q)
        else $error("Brown-out flag not set");
    flag_sticky_a: assert property (
        brownout_flag_q && !wr_cause |=> brownout_flag_q)
        else $error("Brown-out flag dropped without write");
    pll_gate_a: assert property (
        state_q == ST_WAIT && cfg_pll_used && !lock_s2_q |->
        seq_status.clock_gate)
        else $error("Clock released before PLL lock");
    startup_gate_a: assert property (
        state_q == ST_WAIT && !cfg_pll_used && cfg_osc_mode &&
        clk_cnt_q != 32'h0 |-> seq_status.clock_gate)
        else $error("Clock released before start-up timer");
    powerup_hold_a: assert property (
        state_q == ST_WAIT && !pwr_done |=> seq_status.device_reset)
        else $error("Reset released before power-up delay");
    fscm_load_a: assert property (
        state_q == ST_PULSE && pulse_cnt_q == 32'h0 && !detect_s2_q &&
        use_fscm |=> pwr_cnt_q == 32'(FSCM_CYCLES - 1))
        else $error("Clock monitor delay not applied");
    ctrl_unused_a: assert property (
        (reg_ctrl_q & ~brownout_regulator_pkg::REG_CTRL_MASK) == 16'h0)
        else $error("Unused control bits not zero");
    low_power_a: assert property (
        1'b1 |=> reg_drive.low_power ==
        $past(reg_ctrl_q[brownout_regulator_pkg::LP_BIT]))
        else $error("Low-power drive mismatch");
    pll_level_a: assert property (
        reg_ctrl_q[brownout_regulator_pkg::PLL_V_LSB +: 2] ==
        brownout_regulator_pkg::CODE_LOW |=>
        reg_drive.pll_level == brownout_regulator_pkg::LVL_LOW)
        else $error("PLL level decode wrong");
    core_level_a: assert property (
        reg_ctrl_q[brownout_regulator_pkg::CORE_V_LSB +: 2] == 2'h3 |=>
        reg_drive.core_level == brownout_regulator_pkg::LVL_HIGH)
        else $error("Core level decode wrong");
endmodule // brownout_regulator_control

`default_nettype wire

/* verif/tb_brownout_regulator_control.sv */
// Purpose: Self-checking bench for the regulator control and brown-out block
// Assumes: AXI4-Lite master tasks; short timer parameters for simulation
// Notes: Reset release times are compared between clock source choices
`timescale 1ns/1ps
`default_nettype none

module tb_brownout_regulator_control;
    localparam int STARTUP = 12;
    localparam int POWERUP = 8;
    localparam int FSCM = 4;
    localparam int PULSE = brownout_regulator_pkg::RST_PULSE_CYC;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, osc_ctrl = 8'h20;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic detect = 1'b0, c_osc = 1'b0, c_pll = 1'b0, c_xtal = 1'b0;
    logic c_pz = 1'b0, sleep = 1'b0;
    brownout_regulator_pkg::reg_drive_t drv;
    brownout_regulator_pkg::seq_status_t st;
    int n_fail = 0, num_checks = 0, d_none, d_osc, d_fscm, n;

    always #12.5 aclk = ~aclk;

    brownout_regulator_control #(.STARTUP_CYCLES(STARTUP),
        .POWERUP_CYCLES(POWERUP), .FSCM_CYCLES(FSCM)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .brownout_detect(detect),
        .oscillator_control_register(osc_ctrl), .cfg_osc_mode(c_osc),
        .cfg_pll_used(c_pll), .cfg_crystal(c_xtal), .cfg_power_up_timer_zero(c_pz),
        .sleep_mode(sleep), .reg_drive(drv), .seq_status(st), .irq(irq)
    );

    // ********************************
    // Reporting
    // ********************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic timed_out;
        n_fail++;
        $display("mismatch wait expected done seen timeout");
        tally_and_finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [1:0] lvl(input logic [1:0] c);
        case (c)
            2'h1: lvl = brownout_regulator_pkg::LVL_LOW;
            2'h2: lvl = brownout_regulator_pkg::LVL_MID;
            default: lvl = brownout_regulator_pkg::LVL_HIGH;
        endcase
    endfunction

    // ********************************
    // Bus and sequence tasks
    // ********************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] resp);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        if (k >= 100) timed_out;
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        if (k >= 100) timed_out;
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic start_brownout(input logic o, p, x, z);
        @(posedge aclk);
        c_osc <= o;
        c_pll <= p;
        c_xtal <= x;
        c_pz <= z;
        detect <= 1'b1;
        repeat (3) @(posedge aclk);
        detect <= 1'b0;
        n = 0;
        while (st.device_reset !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 20) timed_out;
    endtask

    task automatic time_low(input int b, output int cnt);
        cnt = 0;
        while (st[b] !== 1'b0 && cnt < 300) begin
            @(posedge aclk);
            cnt++;
        end
        if (cnt >= 300) timed_out;
    endtask

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("low_power", drv.low_power, 0);
        axi_read(8'h00, v, r);
        check("ctrl reset", v, 32'h0000_0000);
        axi_write(8'h00, 32'hFFFF_FFFF, 4'hF, r);
        check("ctrl bresp", r, brownout_regulator_pkg::RESP_OKAY);
        axi_read(8'h00, v, r);
        check("ctrl unused", v, 32'h0000_8033);
        repeat (2) @(posedge aclk);
        check("low_power", drv.low_power, 1);
        for (int c = 0; c < 4; c++) begin
            axi_write(8'h00, {26'h0, 2'(c) ^ 2'h3, 2'h0, 2'(c)}, 4'h1, r);
            axi_read(8'h00, v, r);
            check("ctrl codes", v, {16'h0, 8'h80, 2'h0, 2'(c) ^ 2'h3,
                2'h0, 2'(c)});
            check("core level", drv.core_level, lvl(2'(c)));
            check("pll level", drv.pll_level, lvl(2'(c) ^ 2'h3));
        end
        axi_write(8'h00, 32'h0, 4'h2, r);
        axi_read(8'h00, v, r);
        check("ctrl byte1", v, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        check("low_power", drv.low_power, 0);
        axi_read(8'h40, v, r);
        check("unmapped rresp", r, brownout_regulator_pkg::RESP_SLVERR);
        check("unmapped rdata", v, 32'h0);
        axi_write(8'h40, 32'hFFFF_FFFF, 4'hF, r);
        check("unmapped bresp", r, brownout_regulator_pkg::RESP_SLVERR);
        sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        check("standby", drv.standby, 1);
        $display("test regulator done");
        axi_write(8'h0C, 32'h1, 4'hF, r);
        start_brownout(1'b0, 1'b0, 1'b0, 1'b0);
        check("gate", st.clock_gate, 1);
        time_low(2, d_none);
        check("powerup wait", d_none >= PULSE + POWERUP, 1);
        axi_read(8'h04, v, r);
        check("brownout flag", v & 32'h2, 32'h2);
        check("irq", irq, 1);
        axi_read(8'h08, v, r);
        check("irq status", v, 32'h3);
        axi_write(8'h0C, 32'h0, 4'hF, r);
        check("irq masked", irq, 0);
        axi_write(8'h0C, 32'h1, 4'hF, r);
        axi_write(8'h08, 32'h3, 4'hF, r);
        repeat (2) @(posedge aclk);
        check("irq cleared", irq, 0);
        axi_read(8'h04, v, r);
        check("flag kept", v & 32'h2, 32'h2);
        axi_write(8'h04, 32'h0, 4'hF, r);
        axi_read(8'h04, v, r);
        check("flag clear", v & 32'h2, 32'h0);
        $display("test brownout flag done");
        start_brownout(1'b1, 1'b0, 1'b0, 1'b0);
        time_low(2, d_osc);
        check("startup wait", d_osc >= PULSE + STARTUP, 1);
        check("startup longer", d_osc > d_none, 1);
        sleep <= 1'b0;
        start_brownout(1'b0, 1'b1, 1'b1, 1'b1);
        time_low(2, d_fscm);
        check("fscm shorter", d_fscm < d_none, 1);
        osc_ctrl <= 8'h00;
        start_brownout(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (6) @(posedge aclk);
        check("por wait", st.por_wait, 1);
        repeat (34) @(posedge aclk);
        check("por wait done", st.por_wait, 0);
        check("standby off", drv.standby, 0);
        check("lock gate", st.clock_gate, 1);
        check("lock reset", st.device_reset, 1);
        axi_read(8'h10, v, r);
        check("seq status", v, 32'h6);
        osc_ctrl <= 8'h20;
        time_low(1, n);
        check("lock release", n <= 8, 1);
        time_low(2, n);
        check("reset release", n <= 8, 1);
        $display("test clock sources done");
        tally_and_finish;
    end
endmodule // tb_brownout_regulator_control

`default_nettype wire
